// >>> shared/otgst_defs.svh
// Bit positions, reset values, codes and warm-up stages for the OTG ID and VBUS status block
`ifndef OTGST_DEFS_SVH
`define OTGST_DEFS_SVH

// Bit positions in the USB interrupt status byte
`define OTGST_USB_VBUS_BIT   3'd1
`define OTGST_USB_SOK_BIT    3'd2
`define OTGST_USB_SEND_BIT   3'd3
`define OTGST_USB_ID_GROUNDED_FLAG_BIT  3'd4
// Bit position in the carkit interrupt status byte
`define OTGST_CK_IDOPEN_BIT  3'd0

// ID resistor codes
`define OTGST_RID_GND        3'h0
`define OTGST_RID_75         3'h1
`define OTGST_RID_102K       3'h2
`define OTGST_RID_200K       3'h3
`define OTGST_RID_440K       3'h4
`define OTGST_RID_OPEN       3'h5

// Reset values
`define OTGST_RST_BYTE       8'h00
`define OTGST_RST_RID        3'h5

// Warm-up stages after reset: synchroniser filled, flags settled
`define OTGST_WARM_SAMPLED   2'd2
`define OTGST_WARM_DONE      2'd3

`endif

// >>> shared/otgst_pkg.sv
// Types for the OTG ID and VBUS status block
package otgst_pkg;

	// Enables for the five watched flags
	typedef struct packed {
		logic id_open;
		logic id_gnd;
		logic sess_end;
		logic sess_ok;
		logic bus_ok;
	} otgst_flags_s;

	// Comparator and ID measurement inputs
	typedef struct packed {
		logic       bus_power_ok;
		logic       session_ok;
		logic       session_over;
		logic       id_low;
		logic       id_open;
		logic [2:0] rid_code;
	} otgst_sense_s;

	// Whole block state
	typedef struct packed {
		otgst_sense_s s1;
		otgst_sense_s s2;
		otgst_flags_s flags;
		logic [7:0]   usb_status;
		logic [7:0]   carkit_status;
		logic [2:0]   rid_code;
		logic         rid_valid;
		logic         event_pulse;
		logic         alt_int;
		logic [1:0]   warm;
	} otgst_state_s;

endpackage

// >>> logic/otgst_status.sv
// OTG ID pin and VBUS comparator status and event logic
`timescale 1ns/1ps
`default_nettype none
`include "otgst_defs.svh"

module otgst_status
(
	// Clock and reset
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_srst,
	// Analog comparator and converter pins
	input  wire otgst_pkg::otgst_sense_s i_sense,
	// Link controls
	input  wire logic                   i_id_bias_enable,
	input  wire logic                   i_sync_mode,
	input  wire logic                   i_host_mode,
	input  wire otgst_pkg::otgst_flags_s i_rise_enable,
	input  wire otgst_pkg::otgst_flags_s i_fall_enable,
	// Status toward the link
	output logic [7:0]                  o_usb_status,
	output logic [7:0]                  o_carkit_status,
	output logic [2:0]                  o_rid_code,
	output logic                        o_rid_valid,
	output logic                        o_event,
	output logic                        o_alt_int
);

	otgst_pkg::otgst_state_s st;
	otgst_pkg::otgst_state_s next_st;

	// Bus power flag straight from its comparator
	function automatic logic bus_flag
	(
		input otgst_pkg::otgst_sense_s s
	);
		return s.bus_power_ok;
	endfunction

	// Session-ok flag keeps reading with its events muted
	function automatic logic sess_ok_flag
	(
		input otgst_pkg::otgst_sense_s s
	);
		return s.session_ok;
	endfunction

	// Session-over comparator is off when both enables are clear
	function automatic logic sess_end_flag
	(
		input otgst_pkg::otgst_sense_s s,
		input otgst_pkg::otgst_flags_s re,
		input otgst_pkg::otgst_flags_s fe
	);
		return s.session_over & (re.sess_end | fe.sess_end);
	endfunction

	// ID-grounded flag reads 1 for a floating pin
	function automatic logic id_gnd_flag
	(
		input otgst_pkg::otgst_sense_s s
	);
		return ~s.id_low;
	endfunction

	// ID-open flag needs the bias pull-up
	function automatic logic id_open_flag
	(
		input otgst_pkg::otgst_sense_s s,
		input logic                    bias
	);
		return bias & s.id_open;
	endfunction

	// Flags as the link would read them, session-over gated by its enables and ID-open by the bias
	function automatic otgst_pkg::otgst_flags_s visible
	(
		input otgst_pkg::otgst_sense_s s,
		input otgst_pkg::otgst_flags_s re,
		input otgst_pkg::otgst_flags_s fe,
		input logic                    bias
	);
		otgst_pkg::otgst_flags_s f;
		f.bus_ok   = bus_flag(s);
		f.sess_ok  = sess_ok_flag(s);
		f.sess_end = sess_end_flag(s, re, fe);
		f.id_gnd   = id_gnd_flag(s);
		f.id_open  = id_open_flag(s, bias);
		return f;
	endfunction

	// Flags that went from 0 to 1 with their rise enable set
	function automatic otgst_pkg::otgst_flags_s rise_edges
	(
		input otgst_pkg::otgst_flags_s now_f,
		input otgst_pkg::otgst_flags_s was_f,
		input otgst_pkg::otgst_flags_s en
	);
		return now_f & ~was_f & en;
	endfunction

	// Flags that went from 1 to 0 with their fall enable set
	function automatic otgst_pkg::otgst_flags_s fall_edges
	(
		input otgst_pkg::otgst_flags_s now_f,
		input otgst_pkg::otgst_flags_s was_f,
		input otgst_pkg::otgst_flags_s en
	);
		return ~now_f & was_f & en;
	endfunction

	// ID-grounded edges report only in host mode, ID-open edges only with bias on
	function automatic otgst_pkg::otgst_flags_s report_gate
	(
		input otgst_pkg::otgst_flags_s raw,
		input logic                    host,
		input logic                    bias
	);
		otgst_pkg::otgst_flags_s g;
		g         = raw;
		g.id_gnd  = raw.id_gnd & host;
		g.id_open = raw.id_open & bias;
		return g;
	endfunction

	// USB status byte from the flags
	function automatic logic [7:0] usb_byte
	(
		input otgst_pkg::otgst_flags_s f
	);
		logic [7:0] b;
		b                         = `OTGST_RST_BYTE;
		b[`OTGST_USB_VBUS_BIT]    = f.bus_ok;
		b[`OTGST_USB_SOK_BIT]     = f.sess_ok;
		b[`OTGST_USB_SEND_BIT]    = f.sess_end;
		b[`OTGST_USB_ID_GROUNDED_FLAG_BIT]   = f.id_gnd;
		return b;
	endfunction

	// Carkit status byte from the flags
	function automatic logic [7:0] carkit_byte
	(
		input otgst_pkg::otgst_flags_s f
	);
		logic [7:0] b;
		b                         = `OTGST_RST_BYTE;
		b[`OTGST_CK_IDOPEN_BIT]   = f.id_open;
		return b;
	endfunction

	// Warm-up stage count, saturating once settled
	function automatic logic [1:0] warm_next
	(
		input logic [1:0] w
	);
		logic [1:0] n;
		n = w;
		if (w != `OTGST_WARM_DONE)
		begin
			n = w + 2'h1;
		end
		return n;
	endfunction

	// Synchroniser holds real pin samples from this stage on
	function automatic logic is_sampled
	(
		input logic [1:0] w
	);
		return (w == `OTGST_WARM_SAMPLED) | (w == `OTGST_WARM_DONE);
	endfunction

	// Flags held in state come from real pin samples
	function automatic logic is_settled
	(
		input logic [1:0] w
	);
		return w == `OTGST_WARM_DONE;
	endfunction

	// Any reported edge, once settled
	function automatic logic any_fire
	(
		input otgst_pkg::otgst_flags_s f,
		input logic                    ok
	);
		return ok & (|f);
	endfunction

	// ID-open edge marks the event as alternate
	function automatic logic alt_fire
	(
		input otgst_pkg::otgst_flags_s f,
		input logic                    ok
	);
		return ok & f.id_open;
	endfunction

	// Resistor code may be taken with bias off in synchronous mode
	function automatic logic rid_readable
	(
		input logic sync,
		input logic bias
	);
		return sync & ~bias;
	endfunction

	// Resistor code follows the pins only while it may be read
	function automatic logic [2:0] rid_next
	(
		input logic       capture,
		input logic [2:0] code,
		input logic [2:0] held
	);
		logic [2:0] r;
		r = held;
		if (capture)
		begin
			r = code;
		end
		return r;
	endfunction

	// Flag sets and warm-up stages of the current cycle
	otgst_pkg::otgst_flags_s cur_f;
	otgst_pkg::otgst_flags_s new_f;
	otgst_pkg::otgst_flags_s rise_hit;
	otgst_pkg::otgst_flags_s fall_hit;
	otgst_pkg::otgst_flags_s fire;
	logic                    settled;
	logic                    sampled;

	// Next state
	always_comb
	begin
		// Two-flop synchroniser on the analog pins
		next_st    = st;
		next_st.s1 = i_sense;
		next_st.s2 = st.s1;
		// Warm-up after reset keeps stale zero samples from making events
		sampled      = is_sampled(st.warm);
		settled      = is_settled(st.warm);
		next_st.warm = warm_next(st.warm);
		// Flags as the link reads them
		new_f         = visible(st.s2, i_rise_enable, i_fall_enable, i_id_bias_enable);
		cur_f         = st.flags;
		next_st.flags = new_f;
		// Edge events gated per flag and direction
		rise_hit = rise_edges(new_f, cur_f, i_rise_enable);
		fall_hit = fall_edges(new_f, cur_f, i_fall_enable);
		fire     = report_gate(rise_hit | fall_hit, i_host_mode, i_id_bias_enable);
		// One-cycle event pulses
		next_st.event_pulse = any_fire(fire, settled);
		next_st.alt_int     = alt_fire(fire, settled);
		// Status bytes
		next_st.usb_status    = usb_byte(new_f);
		next_st.carkit_status = carkit_byte(new_f);
		// Resistor code valid only with bias off and in synchronous mode
		next_st.rid_valid = rid_readable(i_sync_mode, i_id_bias_enable);
		next_st.rid_code  = rid_next(next_st.rid_valid & sampled, st.s2.rid_code, st.rid_code);
	end

	// State register
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			// Statuses clear, resistor code reads open
			st <= '0;
			st.rid_code <= `OTGST_RST_RID;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Status bytes straight from flops
	assign o_usb_status    = st.usb_status;
	assign o_carkit_status = st.carkit_status;

	// Resistor code straight from flops
	assign o_rid_code      = st.rid_code;
	assign o_rid_valid     = st.rid_valid;

	// Event pulses straight from flops
	assign o_event         = st.event_pulse;
	assign o_alt_int       = st.alt_int;

endmodule
`default_nettype wire

// >>> tb/otgst_link_model.sv
// Link model that paces the ID read after bias turn-on
`timescale 1ns/1ps
`default_nettype none
module otgst_link_model #(parameter int SETTLE = 8)
(
	// Clock, bias request and read permission
	input  wire logic i_clk_sys,
	input  wire logic i_bias,
	output logic      o_id_ready
);
	// Settle count restarts whenever bias drops
	int cnt;
	always_ff @(posedge i_clk_sys) cnt <= i_bias ? cnt + 32'(cnt < SETTLE) : 0;
	assign o_id_ready = cnt == SETTLE;
endmodule
`default_nettype wire

// >>> tb/otgst_status_monitor.sv
// Output checks for the ID and VBUS status block
`timescale 1ns/1ps
`default_nettype none
module otgst_status_monitor
(
	// Watched ports
	input wire logic                    i_clk_sys, i_srst, i_id_bias_enable, i_sync_mode,
	input wire logic                    o_rid_valid, o_event, o_alt_int,
	input wire otgst_pkg::otgst_sense_s i_sense,
	input wire otgst_pkg::otgst_flags_s i_rise_enable, i_fall_enable,
	input wire logic [7:0]              o_usb_status, o_carkit_status
);
	// Cycles out of reset, saturating at four
	logic [2:0] up;
	always_ff @(posedge i_clk_sys) up <= i_srst ? 3'h0 : up + {2'h0, up != 3'h4};
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	sequence bias_off4; (!i_id_bias_enable)[*4]; endsequence
	a_sok_state: assert property (up == 3'h4 |->
		o_usb_status[2] == $past(i_sense.session_ok, 3)) else $error("sok");
	a_id_grounded_flag_state: assert property (up == 3'h4 |->
		o_usb_status[4] == !$past(i_sense.id_low, 3)) else $error("gnd");
	a_send_gate: assert property ((!(i_rise_enable.sess_end | i_fall_enable.sess_end))[*4] |->
		!o_usb_status[3]) else $error("send");
	a_open_gate: assert property (bias_off4 |-> !o_carkit_status[0]) else $error("open");
	a_spare_zero: assert property ({o_usb_status[7:5], o_usb_status[0], o_carkit_status[7:1]} == 0)
		else $error("spare");
	a_alt_event: assert property (o_alt_int |-> o_event) else $error("alt");
	a_quiet_start: assert property ($fell(i_srst) |-> (!o_event)[*4]) else $error("start");
	a_event_cause: assert property (o_event |-> $changed(o_usb_status) || $changed(o_carkit_status))
		else $error("cause");
	a_rid_valid: assert property (up == 3'h4 |->
		o_rid_valid == $past(i_sync_mode && !i_id_bias_enable)) else $error("rid");
endmodule
bind otgst_status otgst_status_monitor mon (.*);
`default_nettype wire

// >>> tb/otgst_status_bench.sv
// Self-checking bench for the ID and VBUS status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", n, e, v); end end
module otgst_status_bench;
	// Pins, controls and outputs
	logic       i_clk_sys = 1'b0, i_srst = 1'b1, b = 1'b0, h = 1'b0, m = 1'b1, rdy, rv, ev, ai;
	logic [7:0] s = 8'h05, us, ck;
	logic [4:0] re = 5'h00, fe = 5'h00;
	logic [3:0] n, a;
	logic [2:0] rc;
	int         failures = 0, check_count = 0;
	// Clock and instances
	initial forever #5 i_clk_sys = ~i_clk_sys;
	otgst_link_model link (.i_clk_sys(i_clk_sys), .i_bias(b), .o_id_ready(rdy));
	otgst_status dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sense(s), .i_id_bias_enable(b),
		.i_sync_mode(m), .i_host_mode(h), .i_rise_enable(re), .i_fall_enable(fe),
		.o_usb_status(us), .o_carkit_status(ck), .o_rid_code(rc), .o_rid_valid(rv),
		.o_event(ev), .o_alt_int(ai));
	// Drive pins, then count pulses while they settle
	task step(input logic [7:0] v, input logic [3:0] e, input logic [3:0] al);
		@(negedge i_clk_sys) s = v;
		{n, a} = 8'h00;
		repeat (5) @(negedge i_clk_sys) {n, a} = {n + ev, a + ai};
		`CHK("ev", e, n)
		`CHK("alt", al, a)
	endtask
	// Resistor codes with bias off
	task t_rid;
		for (int c = 0; c < 6; c++)
		begin
			step({5'h00, 3'(c)}, 4'h0, 4'h0);
			`CHK("rid", {1'b1, 3'(c)}, {rv, rc})
		end
	endtask
	// Resistor code holds while out of synchronous mode
	task t_sync;
		@(negedge i_clk_sys) m = 1'b0;
		step(8'h02, 4'h0, 4'h0);
		`CHK("rid", 4'h5, {rv, rc})
		@(negedge i_clk_sys) m = 1'b1;
		step(8'h02, 4'h0, 4'h0);
		`CHK("rid", 4'hA, {rv, rc})
	endtask
	// Mid-run reset with a raised pin gives no stray event
	task t_reset;
		@(negedge i_clk_sys) {i_srst, re, s} = {1'b1, 5'h02, 8'h45};
		repeat (3) @(negedge i_clk_sys);
		i_srst = 1'b0;
		step(8'h45, 4'h0, 4'h0);
		`CHK("sok", 1'b1, us[2])
	endtask
	// Rise-only events, then muted events with state still readable
	task t_sok;
		@(negedge i_clk_sys) re = 5'h02;
		step(8'h45, 4'h1, 4'h0);
		step(8'h05, 4'h0, 4'h0);
		@(negedge i_clk_sys) re = 5'h00;
		step(8'h45, 4'h0, 4'h0);
		`CHK("sok", 1'b1, us[2])
	endtask
	// Session-over reads while enabled, 0 once disabled
	task t_send;
		@(negedge i_clk_sys) {re, fe} = 10'h084;
		step(8'h25, 4'h1, 4'h0);
		`CHK("send", 1'b1, us[3])
		@(negedge i_clk_sys) {re, fe} = 10'h000;
		step(8'h25, 4'h0, 4'h0);
		`CHK("send", 1'b0, us[3])
	endtask
	// Grounded ID events only in host mode
	task t_gnd;
		@(negedge i_clk_sys) {h, re, fe} = 11'h508;
		step(8'h15, 4'h1, 4'h0);
		`CHK("gnd", 1'b0, us[4])
		@(negedge i_clk_sys) h = 1'b0;
		step(8'h05, 4'h0, 4'h0);
		`CHK("gnd", 1'b1, us[4])
	endtask
	// Bias on: ID-open rise and fall both raise alt events
	task t_open;
		@(negedge i_clk_sys) {b, re, fe} = 11'h610;
		for (int k = 0; k < 20 && !rdy; k++) @(negedge i_clk_sys);
		`CHK("rdy", 1'b1, rdy)
		if (!rdy) give_verdict;
		step(8'h0D, 4'h1, 4'h1);
		`CHK("open", 2'b11, {us[4], ck[0]})
		step(8'h05, 4'h1, 4'h1);
		`CHK("open", 2'b10, {us[4], ck[0]})
		@(negedge i_clk_sys) {b, re, fe} = 11'h000;
	endtask
	// Counts and verdict
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Reset, then the scenarios
	initial
	begin
		repeat (3) @(negedge i_clk_sys);
		i_srst = 1'b0;
		t_rid; t_sync; t_sok; t_send; t_gnd; t_open; t_reset;
		give_verdict;
	end
endmodule
`default_nettype wire
